// *** rtl/uart_tx_pkg.sv ***
// Constants and types shared by the transmit line control block
package uart_tx_pkg;

   // ------------------------------------------------------------
   // Widths and depths
   // ------------------------------------------------------------
   localparam int ADDR_W      = 8;
   localparam int DATA_W      = 32;
   localparam int CHAR_W      = 8;
   localparam int QUEUE_DEPTH = 8;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] TX_DATA_OFS   = 8'h00;
   localparam logic [7:0] TX_STATUS_OFS = 8'h18;
   localparam logic [7:0] TX_LINE_OFS   = 8'h2C;
   localparam logic [7:0] PORT_CTRL_OFS = 8'h30;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int LC_BREAK_POS = 0;
   localparam int LC_PAR_POS   = 1;
   localparam int LC_EVEN_POS  = 2;
   localparam int LC_STOP2_POS = 3;
   localparam int LC_QUEUE_POS = 4;
   localparam int LC_LEN_POS   = 5;
   localparam int LC_FIXED_POS = 7;
   localparam int PC_EN_POS    = 0;
   localparam int PC_PATH_POS  = 8;
   localparam int ST_BUSY_POS  = 0;
   localparam int ST_FULL_POS  = 1;
   localparam int ST_EMPTY_POS = 2;
   localparam int ST_BRK_POS   = 3;

   // ------------------------------------------------------------
   // Reset values and timing
   // ------------------------------------------------------------
   localparam logic [7:0] LINE_RESET    = 8'h00;
   localparam logic       EN_RESET      = 1'b0;
   localparam logic       PATH_ON_RESET = 1'b1;
   localparam logic [4:0] BIT_CYCLES    = 5'h10;

   typedef enum logic [2:0] {
      S_IDLE, S_START, S_DATA, S_PARITY, S_STOP, S_BREAK
   } tx_state_t;

endpackage : uart_tx_pkg

// *** rtl/uart_tx_line_control.sv ***
// Transmit line control with character queue
// Operation
// - Break waits for current character end, then holds line low until cleared.
// - Queued characters are neither sent nor dropped during a break.
// - Parity bit is appended only when parity is switched on.
// - Even selection gives even count of ones over data and parity, else odd.
// - Two stop bits when selected, otherwise one.
// - Queue disabled means a single character holding register.
// - Word length field selects five to eight data bits.
// - Fixed parity sends 0 for even selection and 1 for odd.
// - Transmission happens only while the global enable is set; reset clears it.
// - Clearing enable mid character lets that character finish.
// - Transmit path enable, reset to one, also gates transmission.

// ------------------------------------------------------------
// Character queue
// ------------------------------------------------------------
module tx_queue_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             limit_one,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   assign in_ready  = limit_one ? (count_reg == '0) : (count_reg != FULL_CNT);
   assign out_valid = (count_reg != '0);
   assign out_data  = mem_reg[rd_ptr_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

   holding_one_a: assert property (@(posedge clk_sys) disable iff (rst)
      (limit_one && count_reg != '0) |-> !in_ready)
      else $error("holding register accepted a second character");

endmodule : tx_queue_fifo

// ------------------------------------------------------------
// Top level
// ------------------------------------------------------------
module uart_tx_line_control (
   input  wire logic                          clk_sys,
   input  wire logic                          rst,
   input  wire logic [uart_tx_pkg::ADDR_W-1:0] addr,
   input  wire logic [uart_tx_pkg::DATA_W-1:0] wr_data,
   input  wire logic                          wr_en,
   input  wire logic                          rd_en,
   output logic      [uart_tx_pkg::DATA_W-1:0] rd_data,
   output logic                               tx_out
);
   import uart_tx_pkg::*;

   logic [7:0]        line_reg;
   logic              en_reg;
   logic              path_on_reg;
   logic [DATA_W-1:0] rd_data_reg;
   logic              tx_reg;
   tx_state_t         state_reg;
   logic [4:0]        baud_cnt_reg;
   logic [2:0]        bit_idx_reg;
   logic              stop_idx_reg;
   logic [CHAR_W-1:0] shift_reg;
   logic              f_par_reg;
   logic              f_even_reg;
   logic              f_two_reg;
   logic              f_fixed_reg;
   logic [1:0]        f_len_reg;
   logic              par_bit_reg;

   logic              q_in_ready;
   logic              q_out_valid;
   logic [CHAR_W-1:0] q_out_data;
   logic              q_pop;
   logic              bit_tick;
   logic              can_start;
   logic [2:0]        last_idx;
   logic [CHAR_W-1:0] masked;
   logic              send_break;

   function automatic logic [CHAR_W-1:0] mask_len(input logic [CHAR_W-1:0] d,
                                                  input logic [1:0] len);
      logic [CHAR_W-1:0] m;
      m = 8'hFF >> (2'h3 - len);
      return d & m;
   endfunction : mask_len

   function automatic logic parity_of(input logic [CHAR_W-1:0] d, input logic [1:0] len,
                                      input logic even, input logic fixed);
      logic ones;
      ones = ^mask_len(d, len);
      if (fixed) begin
         return !even;
      end
      return even ? ones : !ones;
   endfunction : parity_of

   // ------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------
   assign send_break = line_reg[LC_BREAK_POS];

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         line_reg    <= LINE_RESET;
         en_reg      <= EN_RESET;
         path_on_reg <= PATH_ON_RESET;
      end else if (wr_en) begin
         if (addr == TX_LINE_OFS) begin
            line_reg <= wr_data[7:0];
         end
         if (addr == PORT_CTRL_OFS) begin
            en_reg      <= wr_data[PC_EN_POS];
            path_on_reg <= wr_data[PC_PATH_POS];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rd_data_reg <= '0;
      end else begin
         rd_data_reg <= '0;
         if (rd_en) begin
            unique case (addr)
               TX_LINE_OFS: begin
                  rd_data_reg[7:0] <= line_reg;
               end
               PORT_CTRL_OFS: begin
                  rd_data_reg[PC_EN_POS]   <= en_reg;
                  rd_data_reg[PC_PATH_POS] <= path_on_reg;
               end
               TX_STATUS_OFS: begin
                  rd_data_reg[ST_BUSY_POS]  <= (state_reg != S_IDLE);
                  rd_data_reg[ST_FULL_POS]  <= !q_in_ready;
                  rd_data_reg[ST_EMPTY_POS] <= !q_out_valid;
                  rd_data_reg[ST_BRK_POS]   <= (state_reg == S_BREAK);
               end
               default: begin
                  rd_data_reg <= '0;
               end
            endcase
         end
      end
   end

   assign rd_data = rd_data_reg;

   // ------------------------------------------------------------
   // Queue
   // ------------------------------------------------------------
   tx_queue_fifo #(
      .WIDTH (CHAR_W),
      .DEPTH (QUEUE_DEPTH)
   ) u_queue (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .limit_one (!line_reg[LC_QUEUE_POS]),
      .in_valid  (wr_en && addr == TX_DATA_OFS),
      .in_ready  (q_in_ready),
      .in_data   (wr_data[CHAR_W-1:0]),
      .out_valid (q_out_valid),
      .out_ready (q_pop),
      .out_data  (q_out_data)
   );

   // ------------------------------------------------------------
   // Frame sequencer
   // ------------------------------------------------------------
   assign can_start = en_reg && path_on_reg && !send_break;
   assign q_pop     = (state_reg == S_IDLE) && can_start && q_out_valid;
   assign bit_tick  = (baud_cnt_reg == BIT_CYCLES - 5'h01);
   assign last_idx  = 3'h4 + {1'b0, f_len_reg};
   assign masked    = mask_len(shift_reg, f_len_reg);

   always_ff @(posedge clk_sys) begin
      if (rst || state_reg == S_IDLE || state_reg == S_BREAK || bit_tick) begin
         baud_cnt_reg <= '0;
      end else begin
         baud_cnt_reg <= baud_cnt_reg + 5'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg    <= S_IDLE;
         bit_idx_reg  <= '0;
         stop_idx_reg <= 1'b0;
         shift_reg    <= '0;
         f_par_reg    <= 1'b0;
         f_even_reg   <= 1'b0;
         f_two_reg    <= 1'b0;
         f_fixed_reg  <= 1'b0;
         f_len_reg    <= '0;
         par_bit_reg  <= 1'b0;
      end else begin
         unique case (state_reg)
            S_IDLE: begin
               if (send_break && en_reg && path_on_reg) begin
                  state_reg <= S_BREAK;
               end else if (q_pop) begin
                  state_reg   <= S_START;
                  shift_reg   <= q_out_data;
                  f_par_reg   <= line_reg[LC_PAR_POS];
                  f_even_reg  <= line_reg[LC_EVEN_POS];
                  f_two_reg   <= line_reg[LC_STOP2_POS];
                  f_fixed_reg <= line_reg[LC_FIXED_POS];
                  f_len_reg   <= line_reg[LC_LEN_POS +: 2];
                  par_bit_reg <= parity_of(q_out_data, line_reg[LC_LEN_POS +: 2],
                                           line_reg[LC_EVEN_POS], line_reg[LC_FIXED_POS]);
               end
            end
            S_START: begin
               if (bit_tick) begin
                  state_reg   <= S_DATA;
                  bit_idx_reg <= '0;
               end
            end
            S_DATA: begin
               if (bit_tick) begin
                  if (bit_idx_reg == last_idx) begin
                     state_reg <= f_par_reg ? S_PARITY : S_STOP;
                  end
                  bit_idx_reg <= bit_idx_reg + 3'h1;
                  stop_idx_reg <= 1'b0;
               end
            end
            S_PARITY: begin
               if (bit_tick) begin
                  state_reg <= S_STOP;
               end
            end
            S_STOP: begin
               if (bit_tick) begin
                  if (f_two_reg && !stop_idx_reg) begin
                     stop_idx_reg <= 1'b1;
                  end else begin
                     state_reg <= S_IDLE;
                  end
               end
            end
            S_BREAK: begin
               if (!send_break) begin
                  state_reg <= S_IDLE;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Line driver
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tx_reg <= 1'b1;
      end else begin
         unique case (state_reg)
            S_START:  tx_reg <= 1'b0;
            S_DATA:   tx_reg <= shift_reg[bit_idx_reg];
            S_PARITY: tx_reg <= par_bit_reg;
            S_BREAK:  tx_reg <= 1'b0;
            default:  tx_reg <= 1'b1;
         endcase
      end
   end

   assign tx_out = tx_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   idle_high_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == S_IDLE || state_reg == S_STOP) |=> tx_reg)
      else $error("line not high while idle or stop");

   break_low_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == S_BREAK) |=> !tx_reg)
      else $error("line not low during break");

   break_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == S_BREAK) |-> !q_pop)
      else $error("queue drained during break");

   enable_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == S_IDLE && !(en_reg && path_on_reg)) |=> state_reg != S_START)
      else $error("frame started while disabled");

   finish_char_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == S_DATA && !bit_tick) |=> state_reg == S_DATA)
      else $error("character cut short");

   parity_slot_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == S_DATA && bit_tick && bit_idx_reg == last_idx)
      |=> state_reg == (f_par_reg ? S_PARITY : S_STOP))
      else $error("parity slot wrong");

   parity_value_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == S_PARITY && !f_fixed_reg)
      |=> tx_reg == (f_even_reg ? ^masked : !(^masked)))
      else $error("parity value wrong");

   fixed_parity_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == S_PARITY && f_fixed_reg) |=> tx_reg == !f_even_reg)
      else $error("fixed parity value wrong");

   two_stop_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == S_STOP && bit_tick && f_two_reg && !stop_idx_reg)
      |=> state_reg == S_STOP)
      else $error("second stop bit missing");

   word_len_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == S_DATA && bit_tick && bit_idx_reg != last_idx)
      |=> state_reg == S_DATA)
      else $error("data bits ended early");

endmodule : uart_tx_line_control

// *** sim/uart_line_peer.sv ***
// Line side receiver model that decodes frames seen on the serial line
module uart_line_peer (
   input  wire logic       clk_sys,
   input  wire logic       line,
   input  wire logic [3:0] nbits,
   input  wire logic       par_on,
   input  wire logic       two_stop,
   output int              good_cnt,
   output int              bad_cnt,
   output logic      [7:0] got_data,
   output logic            got_par
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ok;
   // ------------------------------------------------------------
   // Frame decoder, samples each bit in its middle
   // ------------------------------------------------------------
   initial begin
      good_cnt = 0;
      bad_cnt  = 0;
      got_data = 8'h00;
      got_par  = 1'b0;
      forever begin
         @(posedge clk_sys iff line === 1'b1);
         @(posedge clk_sys iff line === 1'b0);
         repeat (8) @(posedge clk_sys);
         ok       = (line === 1'b0);
         got_data = 8'h00;
         for (int i = 0; i < nbits; i++) begin
            repeat (16) @(posedge clk_sys);
            got_data[i] = line;
         end
         if (par_on) begin
            repeat (16) @(posedge clk_sys);
            got_par = line;
         end
         for (int s = 0; s <= int'(two_stop); s++) begin
            repeat (16) @(posedge clk_sys);
            ok = ok && (line === 1'b1);
         end
         if (ok) good_cnt++;
         else bad_cnt++;
      end
   end
endmodule : uart_line_peer

// *** sim/uart_tx_line_control_tb_top.sv ***
// Self-checking bench for the transmit line control block
module uart_tx_line_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import uart_tx_pkg::*;
   logic              clk_sys;
   logic              rst;
   logic              wr_en;
   logic              rd_en;
   logic              tx_out;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wr_data;
   logic [DATA_W-1:0] rd_data;
   logic [3:0]        nbits;
   logic              par_on;
   logic              two_stop;
   logic              got_par;
   logic [7:0]        got_data;
   int                good_cnt;
   int                bad_cnt;
   int                error_cnt;
   int                n_tests;

   uart_tx_line_control dut (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .tx_out(tx_out));
   uart_line_peer peer (.clk_sys(clk_sys), .line(tx_out), .nbits(nbits), .par_on(par_on),
      .two_stop(two_stop), .good_cnt(good_cnt), .bad_cnt(bad_cnt), .got_data(got_data), .got_par(got_par));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge clk_sys);
      wr_en   <= 1'b0;
   endtask : wr

   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp,
                        input logic [31:0] m = 32'hFFFFFFFF);
      @(posedge clk_sys);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1;
      chk(what, exp, rd_data & m);
   endtask : rdchk

   task automatic wait_good(input int n);
      int k;
      k = 0;
      while (good_cnt < n && k < 2500) begin
         @(posedge clk_sys);
         k++;
      end
      chk("frame count", n, good_cnt);
      repeat (16) @(posedge clk_sys);
   endtask : wait_good

   task automatic set_fmt(input logic [7:0] lc);
      nbits    = 4'd5 + 4'(lc[6:5]);
      par_on   = lc[LC_PAR_POS];
      two_stop = lc[LC_STOP2_POS];
      wr(TX_LINE_OFS, {24'h0, lc});
   endtask : set_fmt

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic test_reset;
      chk("idle line", 1, tx_out);
      rdchk("line ctrl reset", TX_LINE_OFS, 32'h0);
      rdchk("port ctrl reset", PORT_CTRL_OFS, 32'h100);
      rdchk("unmapped", 8'h40, 32'h0);
      rdchk("status empty", TX_STATUS_OFS, 32'h4);
      wr(TX_LINE_OFS, 32'hFFFFFFFF);
      rdchk("line ctrl bits", TX_LINE_OFS, 32'hFF);
   endtask : test_reset

   task automatic test_queue;
      set_fmt(8'h60);
      wr(TX_DATA_OFS, 32'h11);
      wr(TX_DATA_OFS, 32'h22);
      rdchk("holding full", TX_STATUS_OFS, 32'h2);
      repeat (250) @(posedge clk_sys);
      chk("idle while off", 0, good_cnt);
      wr(PORT_CTRL_OFS, 32'h101);
      wait_good(1);
      chk("held char", 32'h11, got_data);
      repeat (250) @(posedge clk_sys);
      chk("second dropped", 1, good_cnt);
      wr(PORT_CTRL_OFS, 32'h100);
      set_fmt(8'h70);
      for (int i = 0; i < 9; i++) wr(TX_DATA_OFS, 32'h40 + i);
      rdchk("queue full", TX_STATUS_OFS, 32'h2);
      wr(PORT_CTRL_OFS, 32'h101);
      wait_good(9);
      chk("last queued", 32'h47, got_data);
      rdchk("queue drained", TX_STATUS_OFS, 32'h4);
   endtask : test_queue

   task automatic test_formats;
      logic [7:0] fmt [7] = '{8'h00, 8'h2A, 8'h46, 8'h6E, 8'hE2, 8'hE6, 8'h84};
      logic [7:0] d;
      for (int i = 0; i < 7; i++) begin
         set_fmt(fmt[i]);
         d = (fmt[i] ^ 8'h5B) & (8'hFF >> (8 - nbits));
         wr(TX_DATA_OFS, {24'h0, fmt[i] ^ 8'h5B});
         wr(TX_DATA_OFS, {24'h0, fmt[i] ^ 8'h5B});
         wait_good(good_cnt + 2);
         chk("data bits", d, got_data);
         if (par_on)
            chk("parity", fmt[i][7] ? !fmt[i][2] : (fmt[i][2] ? ^d : ~^d), got_par);
      end
   endtask : test_formats

   task automatic test_break;
      int n;
      int highs;
      n     = good_cnt;
      highs = 0;
      set_fmt(8'h70);
      wr(TX_DATA_OFS, 32'hA5);
      repeat (40) @(posedge clk_sys);
      wr(TX_LINE_OFS, 32'h71);
      wr(TX_DATA_OFS, 32'h3C);
      wr(TX_DATA_OFS, 32'hC3);
      wait_good(n + 1);
      chk("char before break", 32'hA5, got_data);
      for (int i = 0; i < 200; i++) begin
         @(posedge clk_sys);
         if (tx_out !== 1'b0) highs++;
      end
      chk("break held low", 0, highs);
      rdchk("break status", TX_STATUS_OFS, 32'h8, 32'hE);
      wr(TX_LINE_OFS, 32'h70);
      wait_good(n + 3);
      chk("kept char", 32'hC3, got_data);
      chk("break frames", 1, bad_cnt);
   endtask : test_break

   task automatic test_enable;
      int n;
      n = good_cnt;
      wr(TX_DATA_OFS, 32'h5A);
      wr(TX_DATA_OFS, 32'h96);
      repeat (60) @(posedge clk_sys);
      wr(PORT_CTRL_OFS, 32'h100);
      wait_good(n + 1);
      chk("finished char", 32'h5A, got_data);
      repeat (250) @(posedge clk_sys);
      chk("halted", n + 1, good_cnt);
      wr(PORT_CTRL_OFS, 32'h001);
      wr(TX_DATA_OFS, 32'h77);
      repeat (250) @(posedge clk_sys);
      chk("path off", n + 1, good_cnt);
      wr(PORT_CTRL_OFS, 32'h101);
      wait_good(n + 3);
      chk("resumed char", 32'h77, got_data);
   endtask : test_enable

   task automatic tally_and_finish;
      if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish

   // ------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (40000) @(posedge clk_sys);
      error_cnt++;
      tally_and_finish();
   end

   initial begin
      error_cnt = 0;
      n_tests   = 0;
      rst       = 1'b1;
      wr_en     = 1'b0;
      rd_en     = 1'b0;
      addr      = 8'h00;
      wr_data   = 32'h0;
      nbits     = 4'd5;
      par_on    = 1'b0;
      two_stop  = 1'b0;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      test_reset();
      test_queue();
      test_formats();
      test_break();
      test_enable();
      tally_and_finish();
   end
endmodule : uart_tx_line_control_tb_top
